//--- logic/dmh_consts.svh
`ifndef DMH_CONSTS_SVH
`define DMH_CONSTS_SVH
// ****************************************
// Timing counts in CORE_CLK cycles
// ****************************************
`define DMH_CLK_NS 20
`define DMH_PHASE_NS 60
`define DMH_PHASE_CYC 3'((`DMH_PHASE_NS + `DMH_CLK_NS - 1) / `DMH_CLK_NS)
`define DMH_CNT_W 3
`define DMH_CNT_ZERO 3'h0
`define DMH_CNT_ONE 3'h1
`define DMH_BYTE_ZERO 8'h00
`endif

//--- logic/dmh_pkg.sv
`default_nettype none
package dmh_pkg;
   // Host sequencer states
   typedef enum logic [3:0] {
      DMH_IDLE, DMH_ADDR, DMH_AS_HI, DMH_DS_LO, DMH_DS_HI,
      DMH_SS_LO, DMH_SS_HI, DMH_DMA_LO, DMH_DMA_HI
   } dmh_state_e;
endpackage
`default_nettype wire

//--- logic/dmh_host.sv
`include "dmh_consts.svh"
`default_nettype none
// How it works
// - Muxed bus carries address, then data
// - Hold address, select, acknowledge during strobe
// - Direction high reads, low writes
// - Data strobe times each muxed non-DMA transfer
// - DMA strobe moves each muxed-mode DMA byte; separate mode uses DMA grant
// - Upstream priority grant feeds device input
// - Read strobe low reads, separate mode
// - Store strobe low writes, separate mode
// - Select low qualifies separate-mode strobes
// - DMA grant low acknowledges requested transfer
// - Control/data line classifies data byte
// - Muxed mode identical on both ports
module dmh_host import dmh_pkg::*; (
   input wire logic CORE_CLK,          // 50 MHz clock
   input wire logic SYS_RST,           // Sync reset, high
   input wire logic REQ_START,         // Pulse: start access
   input wire logic REQ_SEPARATE,      // 1 separate-strobe mode, 0 muxed
   input wire logic REQ_READ,          // 1 read, 0 write
   input wire logic REQ_DMA,           // 1 DMA byte transfer
   input wire logic REQ_CTRL,          // Control byte (separate mode)
   input wire logic REQ_ACK_IRQ,       // Interrupt acknowledge cycle (muxed)
   input wire logic [7:0] REQ_ADDR,    // Register address
   input wire logic [7:0] REQ_WDATA,   // Write data
   input wire logic PRIO_GRANT,        // Upstream priority from chain
   output logic REQ_BUSY,              // Access in progress
   output logic REQ_DONE,              // Pulse: access finished
   output logic [7:0] REQ_RDATA,       // Read data
   output logic DEV_IRQ,               // Device interrupt pending
   output logic DEV_DMA_REQ,           // Device requests DMA
   input wire logic [7:0] BUS_I,       // Bus pins in
   output logic [7:0] BUS_O,           // Bus pins out
   output logic BUS_OE,                // High while host drives bus
   output logic ADDR_STROBE_N,         // Address strobe
   output logic XFER_STROBE_N,         // Data strobe
   output logic DIR_READ_HIGH,         // Direction
   output logic PORT_SELECT_N,         // Muxed select
   output logic IRQ_ACKNOWLEDGE_N,     // Interrupt acknowledge
   output logic DMA_STROBE_N,          // DMA strobe
   output logic READ_STROBE_N,         // Separate read
   output logic STORE_STROBE_N,        // Separate write
   output logic SELECT_N,              // Separate select
   output logic DMA_GRANT_N,           // DMA acknowledge
   output logic CTRL_OR_DATA_SEL,      // Control/data class
   output logic PRIO_ENABLE_IN,        // Priority grant to device
   input wire logic DMA_REQUEST_OR_HOLD_N, // Request/wait from device
   input wire logic IRQ_OUT_N          // Open-drain interrupt line
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [7:0] bus_m, bus_s;           // Bus data sync
   logic hold_m, hold_s;               // Request/wait sync
   logic irq_m, irq_s;                 // Interrupt sync
   // Two flops on every pin input; first stage read only by the second
   always_ff @(posedge CORE_CLK) begin
      bus_m <= BUS_I;
      bus_s <= bus_m;
      hold_m <= DMA_REQUEST_OR_HOLD_N;
      hold_s <= hold_m;
      irq_m <= IRQ_OUT_N;
      irq_s <= irq_m;
   end

   // ****************************************
   // Status to user
   // ****************************************
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         DEV_IRQ <= 1'b0;
         DEV_DMA_REQ <= 1'b0;
         PRIO_ENABLE_IN <= 1'b0;
      end else begin
         DEV_IRQ <= ~irq_s;
         DEV_DMA_REQ <= ~hold_s & ~REQ_BUSY;
         PRIO_ENABLE_IN <= PRIO_GRANT;
      end
   end

   // ****************************************
   // Access sequencer
   // ****************************************
   dmh_state_e state;                  // Current phase
   logic [`DMH_CNT_W-1:0] cnt;         // Phase timer
   logic rd, dma;                      // Latched direction and transfer kind
   logic [7:0] wdat;                   // Latched write data
   wire logic phase_end = (cnt == `DMH_CNT_ZERO); // Timer expired
   // Wait stretches a strobe until the device lets go; DMA request is not a wait
   wire logic stall = ~hold_s & ~dma;

   // Phase timer reload helper
   function automatic logic [`DMH_CNT_W-1:0] reload();
      return `DMH_PHASE_CYC - `DMH_CNT_ONE;
   endfunction

   // Phase state and timer
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         state <= DMH_IDLE;
         cnt <= `DMH_CNT_ZERO;
         rd <= 1'b0;
         dma <= 1'b0;
         wdat <= `DMH_BYTE_ZERO;
      end else begin
         if (!phase_end) cnt <= cnt - `DMH_CNT_ONE;
         case (state)
            DMH_IDLE: begin
               if (REQ_START) begin
                  rd <= REQ_READ;
                  dma <= REQ_DMA;
                  wdat <= REQ_WDATA;
                  cnt <= reload();
                  if (REQ_DMA) state <= DMH_DMA_LO;
                  else if (REQ_SEPARATE) state <= DMH_SS_LO;
                  else state <= DMH_ADDR;
               end
            end
            DMH_ADDR: if (phase_end) begin state <= DMH_AS_HI; cnt <= reload(); end
            DMH_AS_HI: if (phase_end) begin state <= DMH_DS_LO; cnt <= reload(); end
            DMH_DS_LO: if (phase_end && !stall) begin state <= DMH_DS_HI; cnt <= reload(); end
            DMH_SS_LO: if (phase_end && !stall) begin state <= DMH_SS_HI; cnt <= reload(); end
            DMH_DMA_LO: if (phase_end) begin state <= DMH_DMA_HI; cnt <= reload(); end
            DMH_DS_HI, DMH_SS_HI, DMH_DMA_HI: if (phase_end) state <= DMH_IDLE;
            default: state <= DMH_IDLE;
         endcase
      end
   end

   // ****************************************
   // Pin drive
   // ****************************************
   wire logic strobe_end = phase_end && !stall; // Leaving a data phase
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         ADDR_STROBE_N <= 1'b1; XFER_STROBE_N <= 1'b1; DIR_READ_HIGH <= 1'b1;
         PORT_SELECT_N <= 1'b1; IRQ_ACKNOWLEDGE_N <= 1'b1; DMA_STROBE_N <= 1'b1;
         READ_STROBE_N <= 1'b1; STORE_STROBE_N <= 1'b1; SELECT_N <= 1'b1;
         DMA_GRANT_N <= 1'b1; CTRL_OR_DATA_SEL <= 1'b0;
         BUS_O <= `DMH_BYTE_ZERO; BUS_OE <= 1'b0;
         REQ_BUSY <= 1'b0; REQ_DONE <= 1'b0; REQ_RDATA <= `DMH_BYTE_ZERO;
      end else begin
         REQ_DONE <= 1'b0;
         case (state)
            DMH_IDLE: if (REQ_START) begin
               REQ_BUSY <= 1'b1;
               DIR_READ_HIGH <= REQ_READ;
               CTRL_OR_DATA_SEL <= REQ_CTRL;
               if (REQ_DMA) begin
                  DMA_STROBE_N <= REQ_SEPARATE;
                  DMA_GRANT_N <= ~REQ_SEPARATE;
                  BUS_O <= REQ_WDATA; BUS_OE <= ~REQ_READ;
               end else if (REQ_SEPARATE) begin
                  SELECT_N <= 1'b0;
                  READ_STROBE_N <= ~REQ_READ;
                  STORE_STROBE_N <= REQ_READ;
                  BUS_O <= REQ_WDATA; BUS_OE <= ~REQ_READ;
               end else begin
                  ADDR_STROBE_N <= 1'b0;
                  PORT_SELECT_N <= 1'b0;
                  IRQ_ACKNOWLEDGE_N <= ~REQ_ACK_IRQ;
                  BUS_O <= REQ_ADDR; BUS_OE <= 1'b1;
               end
            end
            DMH_ADDR: if (phase_end) ADDR_STROBE_N <= 1'b1;
            DMH_AS_HI: if (phase_end) begin
               // Address and select released only after strobe rose
               PORT_SELECT_N <= 1'b1; IRQ_ACKNOWLEDGE_N <= 1'b1;
               XFER_STROBE_N <= 1'b0;
               BUS_O <= wdat; BUS_OE <= ~rd;
            end
            DMH_DS_LO: if (strobe_end) begin
               XFER_STROBE_N <= 1'b1;
               if (rd) REQ_RDATA <= bus_s;
               BUS_OE <= 1'b0;
            end
            DMH_SS_LO: if (strobe_end) begin
               READ_STROBE_N <= 1'b1; STORE_STROBE_N <= 1'b1; SELECT_N <= 1'b1;
               if (rd) REQ_RDATA <= bus_s;
               BUS_OE <= 1'b0;
            end
            DMH_DMA_LO: if (phase_end) begin
               DMA_STROBE_N <= 1'b1; DMA_GRANT_N <= 1'b1;
               if (rd) REQ_RDATA <= bus_s;
               BUS_OE <= 1'b0;
            end
            DMH_DS_HI, DMH_SS_HI, DMH_DMA_HI: if (phase_end) begin
               REQ_BUSY <= 1'b0; REQ_DONE <= 1'b1;
            end
            default: ;
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence s_as_low; ADDR_STROBE_N == 1'b0; endsequence
   AST_SEL_HELD: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      s_as_low |-> PORT_SELECT_N == 1'b0 && BUS_OE) else $error("select dropped during address strobe");
   // Address and acknowledge must not move while the device may still be sampling them
   AST_IACK_HELD: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      s_as_low ##1 s_as_low |-> $stable(IRQ_ACKNOWLEDGE_N) && $stable(BUS_O)) else $error("address phase moved");
   AST_AS_DS: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      !(ADDR_STROBE_N == 1'b0 && XFER_STROBE_N == 1'b0)) else $error("address and data strobe overlap");
   AST_RD_NODRV: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (XFER_STROBE_N == 1'b0 && DIR_READ_HIGH) |-> !BUS_OE) else $error("host drives bus on read");
   AST_SS_SEL: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (READ_STROBE_N == 1'b0 || STORE_STROBE_N == 1'b0) |-> SELECT_N == 1'b0) else $error("strobe without select");
   AST_RW_EXCL: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      !(READ_STROBE_N == 1'b0 && STORE_STROBE_N == 1'b0)) else $error("read and write strobes together");
   AST_WR_DRV: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      $fell(STORE_STROBE_N) |-> BUS_OE) else $error("write strobe without data drive");
   AST_DMA_WIDTH: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      $fell(DMA_STROBE_N) |-> (DMA_STROBE_N == 1'b0) [*3] ##1 DMA_STROBE_N) else $error("DMA strobe width wrong");
   AST_GRANT_WIDTH: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      $fell(DMA_GRANT_N) |-> ##3 DMA_GRANT_N) else $error("DMA grant width wrong");
   AST_AS_WIDTH: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      $fell(ADDR_STROBE_N) |-> (s_as_low) [*3] ##1 ADDR_STROBE_N) else $error("address strobe width wrong");
endmodule // dmh_host
`default_nettype wire

//--- testbench/dmh_dev_model.sv
`default_nettype none
// ********************************
// Behavioural device on the host bus
// ********************************
module dmh_dev_model #(
   parameter logic [7:0] STATUS = 8'h5a,   // Control byte read back
   parameter logic [7:0] DMA_BYTE = 8'hc3  // Byte offered on DMA reads
) (
   input wire logic as_n, ds_n, rd_hi, psel_n, dstb_n, // Muxed strobes
   input wire logic rd_n, wr_n, ce_n, dma_grant_n_n, cd,      // Separate strobes
   input wire logic [7:0] host_o,                      // Host bus value
   input wire logic host_oe,                           // Host drives bus
   input wire logic irq_req, hold_req, prio_in,        // Bench controls; prio_in from host
   output logic [7:0] bus,                             // Resolved bus
   output logic irq_n, hold_n, prio_out,               // Device outputs
   output logic [7:0] last_wr,                         // Last separate write
   output logic last_cd                                // Its class
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sel = 1'b0;            // Latched selection
   logic [7:0] addr = 8'h00;    // Latched address
   logic [7:0] mem [0:255];     // Register space
   logic [7:0] dev_d;           // Byte the device offers
   logic [7:0] held = 8'h00;    // Last bus value
   logic drv;                   // Device drives bus
   initial last_wr = 8'h00;
   initial last_cd = 1'b0;
   // Selection and address taken as the strobe rises
   always @(posedge as_n) begin
      sel = !psel_n;
      addr = host_o;
   end
   // Muxed write lands when the data strobe ends
   always @(posedge ds_n) if (sel && !rd_hi) mem[addr] = host_o;
   // Separate write follows the bus while strobe and select are both low; an edge
   // capture would race the host releasing select in the same step as the strobe
   always @(wr_n, ce_n, host_o, cd) if (!wr_n && !ce_n) begin
      last_wr = host_o;
      last_cd = cd;
   end
   assign dev_d = (!dstb_n || !dma_grant_n_n) ? DMA_BYTE : !ce_n ? (cd ? STATUS : last_wr) : mem[addr];
   assign drv = (sel && rd_hi && !ds_n && as_n) || (!ce_n && !rd_n) || (rd_hi && (!dstb_n || !dma_grant_n_n));
   // Track the last value so a released bus never looks stable
   always @(host_oe, host_o, drv, dev_d) if (host_oe) held = host_o; else if (drv) held = dev_d;
   assign bus = host_oe ? host_o : drv ? dev_d : ~held;
   assign irq_n = !irq_req;
   assign hold_n = !hold_req;
   assign prio_out = prio_in;
endmodule // dmh_dev_model
`default_nettype wire

//--- testbench/dual_mode_cpu_port_interface_bench.sv
`default_nettype none
// ********************************
// Host controller bench
// ********************************
module dual_mode_cpu_port_interface_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, sys_rst = 1'b1, start = 1'b0, sep = 1'b0, rd = 1'b0, dma = 1'b0, ctrl = 1'b0;
   logic ack = 1'b0, prio = 1'b0, irq_req = 1'b0, hold_req = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, bus_o, bus_i, last_wr;
   logic busy, done, dev_irq, dev_dma_req, oe, as_n, ds_n, dir, psel_n, dstb_n, rd_n, wr_n, ce_n, dma_grant_n_n, cd;
   logic prio_dev, irq_n, hold_n, prio_out, last_cd, iack_n, iack_seen;
   int n_errors = 0, num_checks = 0, cyc = 0, n = 0;
   initial forever #10 core_clk = ~core_clk;
   dmh_host u_dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .REQ_START(start), .REQ_SEPARATE(sep),
      .REQ_READ(rd), .REQ_DMA(dma), .REQ_CTRL(ctrl), .REQ_ACK_IRQ(ack), .REQ_ADDR(addr), .REQ_WDATA(wdata),
      .PRIO_GRANT(prio), .REQ_BUSY(busy), .REQ_DONE(done), .REQ_RDATA(rdata), .DEV_IRQ(dev_irq),
      .DEV_DMA_REQ(dev_dma_req), .BUS_I(bus_i), .BUS_O(bus_o), .BUS_OE(oe), .ADDR_STROBE_N(as_n),
      .XFER_STROBE_N(ds_n), .DIR_READ_HIGH(dir), .PORT_SELECT_N(psel_n), .IRQ_ACKNOWLEDGE_N(iack_n),
      .DMA_STROBE_N(dstb_n), .READ_STROBE_N(rd_n), .STORE_STROBE_N(wr_n), .SELECT_N(ce_n),
      .DMA_GRANT_N(dma_grant_n_n), .CTRL_OR_DATA_SEL(cd), .PRIO_ENABLE_IN(prio_dev),
      .DMA_REQUEST_OR_HOLD_N(hold_n), .IRQ_OUT_N(irq_n));
   dmh_dev_model u_dev (.as_n(as_n), .ds_n(ds_n), .rd_hi(dir), .psel_n(psel_n), .dstb_n(dstb_n), .rd_n(rd_n),
      .wr_n(wr_n), .ce_n(ce_n), .dma_grant_n_n(dma_grant_n_n), .cd(cd), .host_o(bus_o), .host_oe(oe), .irq_req(irq_req),
      .hold_req(hold_req), .prio_in(prio_dev), .bus(bus_i), .irq_n(irq_n), .hold_n(hold_n),
      .prio_out(prio_out), .last_wr(last_wr), .last_cd(last_cd));
   // Acknowledge as a device latches it when the address strobe rises
   always @(posedge as_n) iack_seen = !iack_n;
   // Compare and count
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task end_sim;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // One access; n ends as the cycle count from the taking edge to done
   task acc(input logic s, input logic r, input logic d, input logic c, input logic [7:0] ad,
      input logic [7:0] wd, input logic k = 1'b0);
      @(posedge core_clk);
      {start, sep, rd, dma, ctrl, ack, addr, wdata} <= {1'b1, s, r, d, c, k, ad, wd};
      @(posedge core_clk);
      start <= 1'b0;
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (done !== 1'b1 && n < 80);
      // A limit that runs out shows here as a missing done
      chk("access done", 8'(done), 8'h01);
      chk("busy after done", 8'(busy), 8'h00);
   endtask
   task t_muxed;
      acc(0, 0, 0, 0, 8'h3c, 8'ha5);
      chk("mux write cycles", 8'(n), 8'h0c);
      acc(0, 0, 0, 0, 8'h3d, 8'h5a);
      acc(0, 1, 0, 0, 8'h3c, 8'h00);
      chk("mux read 3c", rdata, 8'ha5);
      acc(0, 1, 0, 0, 8'h3c, 8'h00, 1'b1);
      chk("ack latched", 8'(iack_seen), 8'h01);
      acc(0, 1, 0, 0, 8'h3d, 8'h00);
      chk("mux read 3d", rdata, 8'h5a);
      chk("ack cleared", 8'(iack_seen), 8'h00);
      $display("muxed done");
   endtask
   task t_sep;
      acc(1, 0, 0, 0, 8'h00, 8'h96);
      chk("sep write", last_wr, 8'h96);
      chk("sep class data", 8'(last_cd), 8'h00);
      chk("sep cycles", 8'(n), 8'h06);
      acc(1, 0, 0, 1, 8'h00, 8'h69);
      chk("sep class ctrl", 8'(last_cd), 8'h01);
      acc(1, 1, 0, 1, 8'h00, 8'h00);
      chk("sep read ctrl", rdata, 8'h5a);
      acc(0, 1, 1, 0, 8'h00, 8'h00);
      chk("mux dma read", rdata, 8'hc3);
      acc(1, 1, 0, 0, 8'h00, 8'h00);
      chk("sep read data", rdata, 8'h69);
      acc(1, 1, 1, 0, 8'h00, 8'h00);
      chk("sep dma read", rdata, 8'hc3);
      $display("separate and dma done");
   endtask
   task t_lines;
      irq_req <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk("irq seen", 8'(dev_irq), 8'h01);
      irq_req <= 1'b0;
      hold_req <= 1'b1;
      prio <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk("irq gone", 8'(dev_irq), 8'h00);
      chk("dma request", 8'(dev_dma_req), 8'h01);
      chk("prio chain", 8'(prio_out), 8'h01);
      fork
         acc(0, 0, 0, 0, 8'h40, 8'h11);
         begin
            repeat (10) @(posedge core_clk);
            hold_req <= 1'b0;
         end
      join
      chk("wait stretches", 8'(n > 13), 8'h01);
      $display("lines done");
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc > 3000) begin
         n_errors++;
         end_sim();
      end
   end
   initial begin
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      #1;
      chk("idle oe", 8'(oe), 8'h00);
      t_muxed();
      t_sep();
      t_lines();
      end_sim();
   end
endmodule // dual_mode_cpu_port_interface_bench
`default_nettype wire
